// [rsf_pkg.sv]
package rsf_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS   = 40;
	localparam int DEAD_TIME_NS    = 20;
	localparam int PG_FILTER_NS    = 3000;
	localparam int DEAD_CYCLES_RAW = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PG_CYCLES_RAW   = (PG_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] DEAD_CYCLES = 2'((DEAD_CYCLES_RAW < 1) ? 1 : DEAD_CYCLES_RAW);
	localparam logic [6:0] PG_CYCLES   = 7'((PG_CYCLES_RAW < 1) ? 1 : PG_CYCLES_RAW);

	// ****************************************************************
	// Soft start
	// ****************************************************************
	localparam logic [12:0] SS_CYCLES = 13'h1000;
	localparam logic [12:0] SS_LAST   = SS_CYCLES - 13'h0001;
	localparam logic [12:0] SS_RESET  = 13'h0000;

	// ****************************************************************
	// Voltage code and input synchroniser layout
	// ****************************************************************
	localparam int         CODE_W        = 5;
	localparam logic [4:0] CODE_SHUTDOWN = 5'h1f;
	localparam int         SYNC_W        = 18;
	localparam logic [17:0] SYNC_RESET   = 18'h00000;
	localparam int POS_EN     = 17;
	localparam int POS_CODE   = 12;
	localparam int POS_V42    = 11;
	localparam int POS_V40    = 10;
	localparam int POS_V36    = 9;
	localparam int POS_SWCLK  = 8;
	localparam int POS_PWM    = 7;
	localparam int POS_OV     = 6;
	localparam int POS_MIN    = 5;
	localparam int POS_MAX    = 4;
	localparam int POS_SWUV   = 3;
	localparam int POS_WIN    = 2;
	localparam int POS_LINA   = 1;
	localparam int POS_LINB   = 0;

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_OFF  = 3'h0,
		ST_SOFT = 3'h1,
		ST_RUN  = 3'h2,
		ST_OV   = 3'h3,
		ST_UVL  = 3'h4
	} rsf_state_t;

	function automatic logic code_is_valid(input logic [4:0] code);
		code_is_valid = (code != CODE_SHUTDOWN);
	endfunction

endpackage

// [rsf_dead_time.sv]
`timescale 1ns/1ps
module rsf_dead_time
	import rsf_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic want_high,
	input  wire logic want_low,
	output logic      high_drv,
	output logic      low_drv
);
	import rsf_pkg::*;

	logic [1:0] gap;
	logic       gap_done;

	assign gap_done = (gap >= DEAD_CYCLES);

	// ****************************************************************
	// Non-overlapping gate drive
	// ****************************************************************
	// A side turns on only after both sides were off for the full gap,
	// so a slow turn-off can never meet the other side's turn-on.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			high_drv <= 1'b0;
		end else if (high_drv && !want_high) begin
			high_drv <= 1'b0;
		end else if (!high_drv && !low_drv && want_high && gap_done) begin
			high_drv <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			low_drv <= 1'b0;
		end else if (low_drv && (!want_low || want_high)) begin
			low_drv <= 1'b0;
		end else if (!high_drv && !low_drv && want_low && !want_high && gap_done) begin
			low_drv <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			gap <= 2'h0;
		end else if (high_drv || low_drv) begin
			gap <= 2'h0;
		end else if (!gap_done) begin
			gap <= gap + 2'h1;
		end
	end

	no_overlap_a: assert property (@(posedge clk) disable iff (!reset_n)
		!(high_drv && low_drv)) else $error("both gate drives on");

	dead_gap_a: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(high_drv) |-> !low_drv ##1 !low_drv) else $error("low side on too soon");

endmodule // rsf_dead_time

// [rsf_sequencer.sv]
`timescale 1ns/1ps
module rsf_sequencer
	import rsf_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 enable_in,
	input  wire logic [CODE_W-1:0]    voltage_code,
	input  wire logic                 vcc_above_4v2,
	input  wire logic                 vcc_above_4v,
	input  wire logic                 vcc_above_3v6,
	input  wire logic                 switch_clk,
	input  wire logic                 pwm_demand,
	input  wire logic                 out_over_118,
	input  wire logic                 min_trip,
	input  wire logic                 max_trip,
	input  wire logic                 switch_under,
	input  wire logic                 window_ok,
	input  wire logic                 linear_a_feedback,
	input  wire logic                 linear_b_feedback,
	output logic                      high_side_drive,
	output logic                      low_side_drive,
	output logic                      linear_a_gate,
	output logic                      linear_b_gate,
	output logic                      power_good_out,
	output logic                      power_good_pin_oe,
	output logic                      crowbar_out,
	output logic                      softstart_active,
	output logic                      loop_released,
	output logic [11:0]               ramp_level
);
	import rsf_pkg::*;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [SYNC_W-1:0] sync_1;
	logic [SYNC_W-1:0] sync_2;
	logic              swclk_q;
	logic [SYNC_W-1:0] pins;

	assign pins = {enable_in, voltage_code, vcc_above_4v2, vcc_above_4v, vcc_above_3v6,
		switch_clk, pwm_demand, out_over_118, min_trip, max_trip, switch_under,
		window_ok, linear_a_feedback, linear_b_feedback};

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync_1 <= SYNC_RESET;
			sync_2 <= SYNC_RESET;
			swclk_q <= 1'b0;
		end else begin
			sync_1 <= pins;
			sync_2 <= sync_1;
			swclk_q <= sync_2[POS_SWCLK];
		end
	end

	wire              en_s    = sync_2[POS_EN];
	wire [CODE_W-1:0] code_s  = sync_2[POS_CODE +: CODE_W];
	wire              v42_s   = sync_2[POS_V42];
	wire              v40_s   = sync_2[POS_V40];
	wire              v36_s   = sync_2[POS_V36];
	wire              sw_edge = sync_2[POS_SWCLK] && !swclk_q;
	wire              pwm_s   = sync_2[POS_PWM];
	wire              ov_s    = sync_2[POS_OV];
	wire              min_s   = sync_2[POS_MIN];
	wire              max_s   = sync_2[POS_MAX];
	wire              swuv_s  = sync_2[POS_SWUV];
	wire              win_s   = sync_2[POS_WIN];
	wire              lina_s  = sync_2[POS_LINA];
	wire              linb_s  = sync_2[POS_LINB];

	// ****************************************************************
	// Power-on reset with hysteresis
	// ****************************************************************
	// Release needs 4V but re-entry waits for 3.6V, so supply noise near
	// one threshold does not chatter the whole device.
	logic por_active;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			por_active <= 1'b1;
		end else if (por_active && v40_s) begin
			por_active <= 1'b0;
		end else if (!por_active && !v36_s) begin
			por_active <= 1'b1;
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	rsf_state_t  state;
	rsf_state_t  next_state;
	logic [12:0] ss_count;
	logic        abort;
	logic        go;

	// Any of these drops the device back to off and clears every latch.
	assign abort = por_active || !en_s || !code_is_valid(code_s);
	assign go    = en_s && code_is_valid(code_s) && v42_s && !por_active;

	always_comb begin
		next_state = state;
		if (abort) begin
			next_state = ST_OFF;
		end else begin
			case (state)
				ST_OFF: begin
					if (go) begin
						next_state = ST_SOFT;
					end
				end
				ST_SOFT: begin
					if (sw_edge && ss_count == SS_LAST) begin
						next_state = ST_RUN;
					end
				end
				ST_RUN: begin
					if (ov_s) begin
						next_state = ST_OV;
					end else if (swuv_s) begin
						next_state = ST_UVL;
					end
				end
				ST_OV, ST_UVL: begin
					next_state = state;
				end
				default: begin
					next_state = ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ss_count <= SS_RESET;
		end else if (next_state != ST_SOFT) begin
			ss_count <= SS_RESET;
		end else if (sw_edge) begin
			ss_count <= ss_count + 13'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			softstart_active <= 1'b0;
			loop_released    <= 1'b0;
			ramp_level       <= 12'h000;
			crowbar_out      <= 1'b0;
		end else begin
			softstart_active <= (next_state == ST_SOFT);
			loop_released    <= (next_state == ST_RUN);
			ramp_level       <= (next_state == ST_SOFT) ? ss_count[11:0] : 12'h000;
			crowbar_out      <= (next_state == ST_OV);
		end
	end

	// ****************************************************************
	// Linear sections
	// ****************************************************************
	logic lina_off;
	logic linb_off;
	logic lin_live;

	assign lin_live = (next_state == ST_SOFT) || (next_state == ST_RUN);

	always_ff @(posedge clk) begin
		if (!reset_n || abort) begin
			lina_off <= 1'b0;
			linb_off <= 1'b0;
		end else if (state == ST_RUN) begin
			lina_off <= lina_off || !lina_s;
			linb_off <= linb_off || !linb_s;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			linear_a_gate <= 1'b0;
			linear_b_gate <= 1'b0;
		end else begin
			linear_a_gate <= lin_live && !lina_off && !(state == ST_RUN && !lina_s);
			linear_b_gate <= lin_live && !linb_off && !(state == ST_RUN && !linb_s);
		end
	end

	// ****************************************************************
	// Power good
	// ****************************************************************
	// Short excursions are filtered; a linear latch-off pulls low at once.
	logic       all_ok;
	logic [6:0] bad_cnt;

	assign all_ok = win_s && lina_s && linb_s && !lina_off && !linb_off;

	always_ff @(posedge clk) begin
		if (!reset_n || state != ST_RUN || all_ok) begin
			bad_cnt <= 7'h00;
		end else if (bad_cnt != PG_CYCLES) begin
			bad_cnt <= bad_cnt + 7'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			power_good_out <= 1'b0;
		end else if (next_state != ST_RUN) begin
			power_good_out <= 1'b0;
		end else if (!lina_s || !linb_s || lina_off || linb_off) begin
			power_good_out <= 1'b0;
		end else if (all_ok) begin
			power_good_out <= 1'b1;
		end else if (bad_cnt + 7'h01 >= PG_CYCLES) begin
			power_good_out <= 1'b0;
		end
	end

	assign power_good_pin_oe = !power_good_out;

	// ****************************************************************
	// Switching drive
	// ****************************************************************
	// The fast comparators only act once the loop runs; during the ramp
	// the output is meant to sit below target and would trip them.
	logic want_high;
	logic want_low;
	logic duty_on;

	always_comb begin
		duty_on = pwm_s;
		if (max_s) begin
			duty_on = 1'b0;
		end else if (min_s) begin
			duty_on = 1'b1;
		end
	end

	always_comb begin
		want_high = 1'b0;
		want_low  = 1'b0;
		case (state)
			ST_SOFT: begin
				want_high = pwm_s;
				want_low  = !pwm_s;
			end
			ST_RUN: begin
				want_high = duty_on;
				want_low  = !duty_on;
			end
			ST_OV: begin
				want_low = 1'b1;
			end
			default: begin
				want_high = 1'b0;
				want_low  = 1'b0;
			end
		endcase
		if (abort) begin
			want_high = 1'b0;
			want_low  = 1'b0;
		end
	end

	rsf_dead_time rsf_dead_time_inst (
		.clk       (clk),
		.reset_n   (reset_n),
		.want_high (want_high),
		.want_low  (want_low),
		.high_drv  (high_side_drive),
		.low_drv   (low_side_drive)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	start_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state == ST_OFF && go) |=> state == ST_SOFT) else $error("soft start not begun");
	ramp_end_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state == ST_SOFT && sw_edge && ss_count == SS_LAST && !abort) |=> (state == ST_RUN
		&& loop_released)) else $error("soft start did not end");
	pg_soft_low_a: assert property (@(posedge clk) disable iff (!reset_n)
		softstart_active |-> !power_good_out) else $error("power good during soft start");
	por_drives_a: assert property (@(posedge clk) disable iff (!reset_n)
		por_active [*3] |-> (!high_side_drive && !low_side_drive)) else $error("drive in reset");
	por_reenter_a: assert property (@(posedge clk) disable iff (!reset_n)
		(!por_active && !v36_s && !v40_s) |=> por_active) else $error("no power-on reset");
	ov_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state == ST_OV) [*4] |-> (!high_side_drive && low_side_drive)) else $error("ov drive");
	crowbar_fire_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state == ST_RUN && ov_s && !abort) |=> (crowbar_out ##1 (crowbar_out || $past(abort))))
		else $error("crowbar not fired");
	ov_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state == ST_OV && !abort) |=> state == ST_OV) else $error("ov latch lost");
	restart_full_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state == ST_OV && abort) |=> (state == ST_OFF && ss_count == SS_RESET))
		else $error("restart not from zero");
	lin_start_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(state == ST_SOFT) |-> (linear_a_gate && linear_b_gate)) else $error("linear late");
	lin_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state == ST_RUN && !lina_s && !abort) |=> (!linear_a_gate && !power_good_out))
		else $error("linear latch-off missing");
	duty_force_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state == ST_RUN && max_s && !abort) [*2] |-> !high_side_drive) else $error("max trip");
	en_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		!en_s |=> (state == ST_OFF && !crowbar_out)) else $error("enable low not off");
	ss_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
		state == ST_OFF |-> ss_count == SS_RESET) else $error("counter not cleared");

endmodule // rsf_sequencer

// [rsf_far_side.sv]
`timescale 1ns/1ps
module rsf_far_side
	import rsf_pkg::*;
(
	input  wire logic clk,
	input  wire logic linear_a_gate,
	input  wire logic linear_b_gate,
	input  wire logic fail_a,
	input  wire logic fail_b,
	output logic      switch_clk,
	output logic      linear_a_feedback,
	output logic      linear_b_feedback
);
	// The oscillator runs free at half the clock rate, the fastest the synchroniser resolves.
	initial switch_clk = 1'h0;
	always @(negedge clk) begin
		switch_clk <= ~switch_clk;
	end
	// A rail stays above 0.63V only while its pass device is driven and no overload is applied.
	assign linear_a_feedback = linear_a_gate & ~fail_a;
	assign linear_b_feedback = linear_b_gate & ~fail_b;
endmodule // rsf_far_side

// [test_rsf_sequencer.sv]
`timescale 1ns/1ps
module test_rsf_sequencer;
	import rsf_pkg::*;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic              clk, reset_n, enable_in, pwm_demand;
	logic [CODE_W-1:0] voltage_code;
	logic              vcc_above_4v2, vcc_above_4v, vcc_above_3v6;
	logic              out_over_118, min_trip, max_trip, switch_under, window_ok;
	logic              fail_a, fail_b, switch_clk, linear_a_feedback, linear_b_feedback;
	logic              high_side_drive, low_side_drive, linear_a_gate, linear_b_gate;
	logic              power_good_out, power_good_pin_oe, crowbar_out;
	logic              softstart_active, loop_released;
	logic [11:0]       ramp_level;
	int                bad_count, num_checks, sw_edges;

	rsf_sequencer rsf_sequencer_inst (.clk(clk), .reset_n(reset_n), .enable_in(enable_in),
		.voltage_code(voltage_code), .vcc_above_4v2(vcc_above_4v2),
		.vcc_above_4v(vcc_above_4v), .vcc_above_3v6(vcc_above_3v6), .switch_clk(switch_clk),
		.pwm_demand(pwm_demand), .out_over_118(out_over_118), .min_trip(min_trip),
		.max_trip(max_trip), .switch_under(switch_under), .window_ok(window_ok),
		.linear_a_feedback(linear_a_feedback), .linear_b_feedback(linear_b_feedback),
		.high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
		.linear_a_gate(linear_a_gate), .linear_b_gate(linear_b_gate),
		.power_good_out(power_good_out), .power_good_pin_oe(power_good_pin_oe),
		.crowbar_out(crowbar_out), .softstart_active(softstart_active),
		.loop_released(loop_released), .ramp_level(ramp_level));

	rsf_far_side rsf_far_side_inst (.clk(clk), .linear_a_gate(linear_a_gate),
		.linear_b_gate(linear_b_gate), .fail_a(fail_a), .fail_b(fail_b),
		.switch_clk(switch_clk), .linear_a_feedback(linear_a_feedback),
		.linear_b_feedback(linear_b_feedback));

	always #20 clk = ~clk;
	always @(posedge switch_clk) sw_edges++;

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Waits on softstart_active (sel 0) or loop_released (sel 1), never longer than lim cycles.
	task automatic wait_for(input int sel, input int lim);
		int n;
		n = 0;
		while (((sel == 0) ? softstart_active : loop_released) !== 1'h1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (n >= lim) begin
			bad_count++;
			$display("[FAIL] wait %0d timed out", sel);
			test_done();
		end
	endtask

	task automatic drives(input logic hi, input logic lo);
		check("high_side_drive", high_side_drive, hi);
		check("low_side_drive", low_side_drive, lo);
	endtask

	task automatic start_run();
		wait_for(0, 20);
		sw_edges = 0;
		check("ramp_start", ramp_level < 12'h004, 1'h1);
		check("linear_a_gate", linear_a_gate, 1'h1);
		check("linear_b_gate", linear_b_gate, 1'h1);
		settle(200);
		check("power_good_out", power_good_out, 1'h0);
		check("ramp_rise", ramp_level > 12'h040, 1'h1);
		wait_for(1, 9000);
		check("ss_edges", sw_edges >= 4094 && sw_edges <= 4098, 1'h1);
		check("softstart_active", softstart_active, 1'h0);
		settle(4);
		check("power_good_out", power_good_out, 1'h1);
		check("power_good_pin_oe", power_good_pin_oe, 1'h0);
	endtask

	// Both switch drives high at once would short the input rail through the FETs.
	always @(negedge clk) begin
		if (reset_n === 1'h1) check("drive_overlap", high_side_drive & low_side_drive, 1'h0);
	end

	initial begin
		repeat (60000) @(negedge clk);
		bad_count++;
		$display("[FAIL] run timed out");
		test_done();
	end

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		clk = 1'h0;
		reset_n = 1'h0;
		enable_in = 1'h0;
		voltage_code = 5'h1f;
		{vcc_above_4v2, vcc_above_4v, vcc_above_3v6} = 3'h0;
		{pwm_demand, out_over_118, min_trip, max_trip, switch_under} = 5'h00;
		window_ok = 1'h1;
		{fail_a, fail_b} = 2'h0;
		{bad_count, num_checks, sw_edges} = {32'h0, 32'h0, 32'h0};
		settle(2);
		reset_n = 1'h1;
		enable_in = 1'h1;
		voltage_code = 5'h0b;
		settle(10);
		check("softstart_active", softstart_active, 1'h0);
		drives(1'h0, 1'h0);
		check("power_good_pin_oe", power_good_pin_oe, 1'h1);
		{vcc_above_4v, vcc_above_3v6} = 2'h3;
		settle(10);
		check("softstart_active", softstart_active, 1'h0);
		voltage_code = 5'h1f;
		vcc_above_4v2 = 1'h1;
		settle(10);
		check("softstart_active", softstart_active, 1'h0);
		enable_in = 1'h0;
		voltage_code = 5'h0b;
		settle(10);
		check("softstart_active", softstart_active, 1'h0);
		$display("test refusals done");
		enable_in = 1'h1;
		start_run();
		$display("test start done");
		pwm_demand = 1'h1;
		settle(10);
		drives(1'h1, 1'h0);
		pwm_demand = 1'h0;
		min_trip = 1'h1;
		settle(10);
		drives(1'h1, 1'h0);
		{min_trip, max_trip, pwm_demand} = 3'h3;
		settle(10);
		drives(1'h0, 1'h1);
		{max_trip, pwm_demand} = 2'h0;
		$display("test duty override done");
		fail_a = 1'h1;
		settle(10);
		check("linear_a_gate", linear_a_gate, 1'h0);
		check("linear_b_gate", linear_b_gate, 1'h1);
		check("power_good_out", power_good_out, 1'h0);
		fail_a = 1'h0;
		settle(10);
		check("linear_a_gate", linear_a_gate, 1'h0);
		voltage_code = 5'h1f;
		settle(10);
		check("softstart_active", softstart_active, 1'h0);
		voltage_code = 5'h0b;
		start_run();
		$display("test linear latch done");
		window_ok = 1'h0;
		settle(10);
		check("power_good_out", power_good_out, 1'h1);
		settle(80);
		check("power_good_out", power_good_out, 1'h0);
		check("power_good_pin_oe", power_good_pin_oe, 1'h1);
		window_ok = 1'h1;
		settle(5);
		check("power_good_out", power_good_out, 1'h1);
		$display("test window filter done");
		out_over_118 = 1'h1;
		settle(10);
		check("crowbar_out", crowbar_out, 1'h1);
		drives(1'h0, 1'h1);
		check("power_good_out", power_good_out, 1'h0);
		out_over_118 = 1'h0;
		settle(10);
		check("crowbar_out", crowbar_out, 1'h1);
		enable_in = 1'h0;
		settle(10);
		check("crowbar_out", crowbar_out, 1'h0);
		drives(1'h0, 1'h0);
		check("linear_a_gate", linear_a_gate, 1'h0);
		enable_in = 1'h1;
		wait_for(0, 20);
		check("ramp_restart", ramp_level < 12'h004, 1'h1);
		wait_for(1, 9000);
		switch_under = 1'h1;
		settle(10);
		drives(1'h0, 1'h0);
		check("loop_released", loop_released, 1'h0);
		check("power_good_out", power_good_out, 1'h0);
		switch_under = 1'h0;
		settle(10);
		check("loop_released", loop_released, 1'h0);
		drives(1'h0, 1'h0);
		$display("test switch latch-off done");
		$display("test over-voltage done");
		{vcc_above_4v2, vcc_above_4v, vcc_above_3v6} = 3'h0;
		settle(10);
		check("softstart_active", softstart_active, 1'h0);
		drives(1'h0, 1'h0);
		check("linear_b_gate", linear_b_gate, 1'h0);
		vcc_above_3v6 = 1'h1;
		settle(10);
		check("softstart_active", softstart_active, 1'h0);
		{vcc_above_4v2, vcc_above_4v} = 2'h3;
		wait_for(0, 20);
		check("ramp_restart", ramp_level < 12'h004, 1'h1);
		$display("test supply cycle done");
		test_done();
	end
endmodule // test_rsf_sequencer
